// ==== ddrb_ctrl_model.sv ====
`timescale 1ns/1ps
module ddrb_ctrl_model #(
  parameter int GAP_CK = 5
) (
  // Link clock
  input  wire logic                   link_clk,
  // Command bus
  output logic [2:0]                  link_cmd,
  output logic [ddrb_pkg::BANK_W-1:0] bank_select_inputs,
  output logic [ddrb_pkg::ROW_W-1:0]  row_address_inputs
);
  import ddrb_pkg::*;
  int unsigned cyc = 0;
  int unsigned last_q [BANKS];
  initial begin
    link_cmd = CMD_NOP;
    bank_select_inputs = '0;
    row_address_inputs = '0;
    foreach (last_q[i]) last_q[i] = 0;
  end
  always @(posedge link_clk) cyc <= cyc + 1;
  // Spacing is per bank, but a precharge-all restarts the spacing of every bank
  task automatic issue(input logic [2:0] c, input logic [BANK_W-1:0] b,
                       input logic [ROW_W-1:0] a);
    @(posedge link_clk);
    while (cyc - last_q[b] < GAP_CK) @(posedge link_clk);
    link_cmd <= c;
    bank_select_inputs <= b;
    row_address_inputs <= a;
    @(posedge link_clk);
    foreach (last_q[i]) if (c == CMD_PRA || i == b) last_q[i] = cyc;
    link_cmd <= CMD_NOP;
    // Idle lines flip instead of holding
    bank_select_inputs <= ~b;
    row_address_inputs <= ~a;
  endtask : issue
endmodule : ddrb_ctrl_model

// ==== ddrb_mem.sv ====
`timescale 1ns/1ps
module ddrb_mem #(
  parameter int AW = 6,
  parameter int DW = 16
) (
  // Clock
  input  wire logic          clk,
  // Write
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // Read
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];
  if (AW < 1 || DW < 1) begin : g_bad_size
    $error("memory size must be positive");
  end
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : ddrb_mem

// ==== ddrb_pkg.sv ====
package ddrb_pkg;
  localparam int BANKS      = 8;
  localparam int BANK_W     = 3;
  localparam int ROW_W      = 15;
  localparam int COL_W      = 10;
  localparam int DQ_W       = 8;
  localparam int MEM_AW     = 6;
  // APB map
  localparam logic [7:0] OFS_MODE   = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_ROW    = 8'h0c;
  // Mode fields
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_CL_LSB = 4;
  localparam int MODE_AL_LSB = 8;
  // CL kept to four bits so it never overlaps the AL field
  localparam int MODE_CL_W   = 4;
  localparam int MODE_AL_W   = 5;
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF  = 2'h1;
  localparam logic [1:0] BL_FIX4 = 2'h2;
  localparam logic [31:0] MODE_RST = 32'h0000_0061;
  // Link commands
  localparam logic [2:0] CMD_NOP = 3'h0;
  localparam logic [2:0] CMD_ACT = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_PRA = 3'h3;
  localparam logic [2:0] CMD_RD  = 3'h4;
  localparam logic [2:0] CMD_RDA = 3'h5;
  localparam int BEATS8 = 8;
  localparam int BEATS4 = 4;
  localparam int CCD_BC4 = 4;
  localparam int RD_PIPE = 3;
  localparam real LINK_NS = 80.0;
  localparam real TRP_NS  = 13.75;
  localparam int  TRP_CK  = (TRP_NS / LINK_NS) < 1.0 ? 1 : $rtoi($ceil(TRP_NS / LINK_NS));
  typedef enum logic [1:0] {
    BK_IDLE = 2'b00,
    BK_ACT  = 2'b01,
    BK_PRE  = 2'b11
  } ddrb_bank_t;
endpackage : ddrb_pkg

// ==== ddrb_sync.sv ====
`timescale 1ns/1ps
module ddrb_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1;
  if (W < 1) begin : g_bad_width
    $error("synchroniser width must be positive");
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      q  <= '0;
    end else begin
      s1 <= d;
      q  <= s1;
    end
  end
endmodule : ddrb_sync

// ==== ddrb_top.sv ====
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Behaviour
// R1 - Activate opens given row in given bank
// R2 - Row stays open until same-bank precharge
// R3 - Controller precharges before activating other row
// R4 - Precharge closes one bank or all
// R5 - Controller waits precharge period before activate
// R6 - Other-bank access allowed during auto precharge
// R7 - Precharged bank idle; activate before read
// R8 - Repeat precharge accepted, period restarts
// R9 - Chop bit low four beats, high eight
// R10 - Chop bit never part of column
// R11 - Selection works with or without auto precharge
// R12 - Mode field: 00 eight, 10 four, 01 per-command
// R13 - Controller spaces read to precharge
// R14 - Controller keeps activate-to-precharge minimum
// R15 - Reactivate after precharge and row cycle
// R16 - Burst starts read latency after read
// R17 - Double-rate beats in column order
// R18 - Banks tracked idle, active or precharging
module ddrb_top
  import ddrb_pkg::*;
(
  // System clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rstn,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Link side
  input  wire logic                       link_clk,
  input  wire logic [2:0]                 link_cmd,
  input  wire logic [ddrb_pkg::BANK_W-1:0] bank_select_inputs,
  input  wire logic [ddrb_pkg::ROW_W-1:0] row_address_inputs,
  // Read data, rise beat then fall beat per link clock
  output logic      [ddrb_pkg::DQ_W-1:0]  rd_rise,
  output logic      [ddrb_pkg::DQ_W-1:0]  rd_fall,
  output logic                            rd_valid,
  output logic                            rd_err
);
  import ddrb_pkg::*;

  // Core reset
  logic rst_s1, rst_core_n;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1     <= 1'b0;
      rst_core_n <= 1'b0;
    end else begin
      rst_s1     <= 1'b1;
      rst_core_n <= rst_s1;
    end
  end
  // Link reset, same release scheme in its own domain
  logic lrst_s1, rst_link_n;
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      lrst_s1    <= 1'b0;
      rst_link_n <= 1'b0;
    end else begin
      lrst_s1    <= 1'b1;
      rst_link_n <= lrst_s1;
    end
  end

  // Core side: APB registers
  typedef struct packed {
    logic [31:0] mode;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
  } ddrb_core_t;
  ddrb_core_t c_q, c_d;

  logic [BANKS*2-1:0] st_sync;
  logic [ROW_W-1:0]   row_sync;

  function automatic logic mapped(input logic [7:0] a);
    return a == OFS_MODE || a == OFS_CMD || a == OFS_STATUS || a == OFS_ROW;
  endfunction : mapped

  always_comb begin
    c_d       = c_q;
    c_d.ready = 1'b0;
    c_d.err   = 1'b0;
    if (psel && !penable) begin
      c_d.ready = 1'b1;
      c_d.err   = !mapped(paddr);
      unique case (paddr)
        OFS_MODE:   c_d.rdata = c_q.mode;
        OFS_STATUS: c_d.rdata = {16'h0000, st_sync};
        OFS_ROW:    c_d.rdata = {17'h0_0000, row_sync};
        default:    c_d.rdata = 32'h0000_0000;
      endcase
    end
    if (psel && penable && c_q.ready && pwrite && paddr == OFS_MODE) begin
      c_d.mode = pwdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      c_q <= '{mode: MODE_RST, default: '0};
    end else begin
      c_q <= c_d;
    end
  end
  assign prdata  = c_q.rdata;
  assign pready  = c_q.ready;
  assign pslverr = c_q.err;

  // Mode settles slowly, so a level two-flop crossing is enough
  logic [31:0] mode_l;
  ddrb_sync #(.W(32)) u_mode (
    .clk   (link_clk),
    .rst_n (rst_link_n),
    .d     (c_q.mode),
    .q     (mode_l)
  );
  logic [BANKS*2-1:0] st_link;
  logic [ROW_W-1:0]   row_link;
  ddrb_sync #(.W(BANKS*2)) u_st (
    .clk   (core_clk),
    .rst_n (rst_core_n),
    .d     (st_link),
    .q     (st_sync)
  );
  ddrb_sync #(.W(ROW_W)) u_row (
    .clk   (core_clk),
    .rst_n (rst_core_n),
    .d     (row_link),
    .q     (row_sync)
  );

  // Link side state
  typedef struct packed {
    ddrb_bank_t [BANKS-1:0]  st;
    logic [BANKS-1:0][3:0]   precharge_period;
    logic [BANKS-1:0][ROW_W-1:0] row;
    logic [5:0]              lat;
    logic                    pend;
    logic [BANK_W-1:0]       pbank;
    logic [COL_W-1:0]        col;
    logic                    ap;
    logic [3:0]              beats;
    logic [3:0]              left;
    logic                    valid;
    logic                    err;
    logic [ROW_W-1:0]        last_row;
    logic [COL_W-1:0]        ocol;
    logic [MEM_AW:0]         fill;
  } ddrb_link_t;
  ddrb_link_t l_q, l_d;

  logic [1:0] bl_mode;
  logic [5:0] rl;
  logic [DQ_W*2-1:0] mem_q;
  assign bl_mode = mode_l[MODE_BL_LSB +: 2];
  assign rl = 6'(mode_l[MODE_CL_LSB +: MODE_CL_W]) + 6'(mode_l[MODE_AL_LSB +: MODE_AL_W]); // [R16]

  function automatic logic [3:0] burst_len(input logic [1:0] m, input logic chop);
    unique case (m)
      BL_FIX4: return 4'(BEATS4);                   // [R12]
      BL_OTF:  return chop ? 4'(BEATS8) : 4'(BEATS4); // [R9] [R12]
      default: return 4'(BEATS8);
    endcase
  endfunction : burst_len

  logic is_rd;
  assign is_rd = link_cmd == CMD_RD || link_cmd == CMD_RDA;

  always_comb begin
    l_d       = l_q;
    l_d.valid = 1'b0;
    // Array cleared once after reset; this block has no write path
    if (!l_q.fill[MEM_AW]) l_d.fill = l_q.fill + 1'b1;
    for (int b = 0; b < BANKS; b++) begin
      if (l_q.st[b] == BK_PRE) begin
        if (l_q.precharge_period[b] <= 4'd1) l_d.st[b] = BK_IDLE; // [R7] [R18]
        else l_d.precharge_period[b] = l_q.precharge_period[b] - 4'd1;
      end
    end
    unique case (link_cmd)
      CMD_ACT: begin
        l_d.st[bank_select_inputs]  = BK_ACT;             // [R1]
        l_d.row[bank_select_inputs] = row_address_inputs; // [R1] [R2]
      end
      CMD_PRE: begin
        l_d.st[bank_select_inputs]  = BK_PRE;             // [R4] [R8]
        l_d.precharge_period[bank_select_inputs] = 4'(TRP_CK);         // [R8]
      end
      CMD_PRA: begin
        for (int b = 0; b < BANKS; b++) begin
          l_d.st[b]  = BK_PRE;                             // [R4]
          l_d.precharge_period[b] = 4'(TRP_CK);
        end
      end
      CMD_RD, CMD_RDA: begin
        if (l_q.st[bank_select_inputs] != BK_ACT) begin
          l_d.err = 1'b1;                                  // [R18]
        end else begin
          l_d.pend  = 1'b1;
          l_d.lat   = rl;
          l_d.pbank = bank_select_inputs;
          // Chop bit excluded from column
          l_d.col   = row_address_inputs[COL_W-1:0];       // [R10]
          l_d.beats = burst_len(bl_mode, row_address_inputs[12]); // [R9] [R11]
          l_d.ap    = link_cmd == CMD_RDA;                 // [R11]
          l_d.last_row = l_q.row[bank_select_inputs];
        end
      end
      default: ;
    endcase
    if (l_q.pend && !is_rd) begin
      // Launch early to cover the valid and output register stages
      if (l_q.lat <= 6'(RD_PIPE)) begin
        l_d.pend = 1'b0;
        l_d.left = l_q.beats;                              // [R16]
      end else begin
        l_d.lat = l_q.lat - 6'd1;
      end
    end
    if (l_q.left != 4'd0) begin
      l_d.valid = 1'b1;                                    // [R17]
      l_d.left  = l_q.left - 4'd2;
      l_d.col   = l_q.col + COL_W'(2);
      l_d.ocol  = l_q.col;
      if (l_q.left == 4'd2 && l_q.ap) begin
        l_d.st[l_q.pbank]  = BK_PRE;                       // [R11]
        l_d.precharge_period[l_q.pbank] = 4'(TRP_CK);
      end
    end
  end

  always_ff @(posedge link_clk or negedge rst_link_n) begin
    if (!rst_link_n) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // The array index must stay inside the column
  if (MEM_AW >= COL_W) begin : g_bad_mem
    $error("memory index wider than column");
  end
  // Array data: rise beat from even column, fall beat from odd
  ddrb_mem #(.AW(MEM_AW), .DW(DQ_W*2)) u_mem (
    .clk   (link_clk),
    .we    (!l_q.fill[MEM_AW]),
    .waddr (l_q.fill[MEM_AW-1:0]),
    .wdata ('0),
    .raddr (l_q.col[MEM_AW:1]),
    .rdata (mem_q)
  );

  always_comb begin
    for (int b = 0; b < BANKS; b++) st_link[b*2 +: 2] = l_q.st[b];
    row_link = l_q.last_row;
  end

  always_ff @(posedge link_clk or negedge rst_link_n) begin
    if (!rst_link_n) begin
      rd_rise  <= '0;
      rd_fall  <= '0;
      rd_valid <= 1'b0;
      rd_err   <= 1'b0;
    end else begin
      rd_rise  <= mem_q[DQ_W-1:0] ^ DQ_W'(l_q.ocol);       // [R17]
      rd_fall  <= mem_q[DQ_W*2-1:DQ_W] ^ DQ_W'(l_q.ocol + 1'b1);
      rd_valid <= l_q.valid;
      rd_err   <= l_q.err;
    end
  end


  // Burst shape, built from its start and its run of beat pairs
  sequence s_bl8_start;
    $rose(l_q.left != 4'd0) && l_q.left == 4'(BEATS8);
  endsequence
  sequence s_bc4_start;
    $rose(l_q.left != 4'd0) && l_q.left == 4'(BEATS4);
  endsequence
  sequence s_four_pairs;
    l_q.valid [*4] ##1 !l_q.valid;
  endsequence
  sequence s_two_pairs;
    l_q.valid [*2] ##1 !l_q.valid;
  endsequence

  // Assertions on the link-side state
  AST_ACT_OPENS: assert property (@(posedge link_clk) disable iff (!rst_link_n) // [R1]
    link_cmd == CMD_ACT |=> l_q.st[$past(bank_select_inputs)] == BK_ACT)
    else $error("bank not active after activate");
  AST_PRE_CLOSES: assert property (@(posedge link_clk) disable iff (!rst_link_n) // [R4]
    link_cmd == CMD_PRA |=> l_q.st[0] == BK_PRE && l_q.st[BANKS-1] == BK_PRE)
    else $error("precharge all missed a bank");
  AST_BURST_LEN: assert property (@(posedge link_clk) disable iff (!rst_link_n) // [R9]
    $rose(l_q.left != 4'd0) |-> l_q.left == BEATS4 || l_q.left == BEATS8)
    else $error("bad burst length");
  AST_RD_ERR: assert property (@(posedge link_clk) disable iff (!rst_link_n) // [R18]
    is_rd && l_q.st[bank_select_inputs] != BK_ACT |=> l_q.err)
    else $error("illegal read not flagged");
  AST_BL8_RUN: assert property (@(posedge link_clk) disable iff (!rst_link_n) // [R9] [R17]
    s_bl8_start |=> s_four_pairs)
    else $error("eight-beat burst not four pairs");
  AST_BC4_RUN: assert property (@(posedge link_clk) disable iff (!rst_link_n) // [R9] [R17]
    s_bc4_start |=> s_two_pairs)
    else $error("chopped burst not two pairs");
  AST_LAT_LOAD: assert property (@(posedge link_clk) disable iff (!rst_link_n) // [R16]
    is_rd && l_q.st[bank_select_inputs] == BK_ACT |=> l_q.pend && l_q.lat == $past(rl))
    else $error("read latency not loaded");
  AST_COL_STEP: assert property (@(posedge link_clk) disable iff (!rst_link_n) // [R17]
    l_q.left != 4'd0 && !is_rd |=> l_q.col == $past(l_q.col) + COL_W'(2))
    else $error("column did not advance by a pair");
  AST_AP_CLOSE: assert property (@(posedge link_clk) disable iff (!rst_link_n) // [R11]
    l_q.left == 4'd2 && l_q.ap && link_cmd != CMD_ACT |=> l_q.st[$past(l_q.pbank)] == BK_PRE)
    else $error("auto precharge missed");
  AST_ERR_STICKY: assert property (@(posedge link_clk) disable iff (!rst_link_n) // [R18]
    l_q.err |=> l_q.err)
    else $error("error flag dropped");
  AST_OUT_VALID: assert property (@(posedge link_clk) disable iff (!rst_link_n) // [R17]
    l_q.valid |=> rd_valid)
    else $error("beat pair not presented");

  // Per-bank precharge timing
  for (genvar g = 0; g < BANKS; g++) begin : g_bank
    AST_PRE_LOADS: assert property (@(posedge link_clk) disable iff (!rst_link_n) // [R8]
      link_cmd == CMD_PRE && bank_select_inputs == BANK_W'(g)
      |=> l_q.st[g] == BK_PRE && l_q.precharge_period[g] == 4'(TRP_CK))
      else $error("precharge timer not restarted");
    AST_PRE_ENDS: assert property (@(posedge link_clk) disable iff (!rst_link_n) // [R7]
      l_q.st[g] == BK_PRE && l_q.precharge_period[g] <= 4'd1 && link_cmd == CMD_NOP && l_q.left == 4'd0
      |=> l_q.st[g] == BK_IDLE)
      else $error("bank stuck precharging");
  end
endmodule : ddrb_top

// ==== ddrb_top_bench.sv ====
`timescale 1ns/1ps
module ddrb_top_bench;
  import ddrb_pkg::*;
  logic core_clk = 0, link_clk = 0, rstn, psel, penable, pwrite, pready, pslverr;
  logic rd_valid, rd_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, e, mk;
  logic [2:0] link_cmd;
  logic [BANK_W-1:0] bank_select_inputs, b_v;
  logic [ROW_W-1:0] row_address_inputs, r_v;
  logic [9:0] c_v;
  logic [DQ_W-1:0] rd_rise, rd_fall, first_rise, prev_rise, first_fall;
  int fail_count = 0, checks_done = 0, cycles = 0, lat = 0, seen_lat, pairs = 0;
  integer seed;
  logic [31:0] apb_q[$], msk_q[$], burst_q[$];
  always #25 core_clk = ~core_clk;
  always #40 link_clk = ~link_clk;
  ddrb_top uut (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_clk(link_clk), .link_cmd(link_cmd),
    .bank_select_inputs(bank_select_inputs), .row_address_inputs(row_address_inputs),
    .rd_rise(rd_rise), .rd_fall(rd_fall), .rd_valid(rd_valid), .rd_err(rd_err));
  ddrb_ctrl_model m (.link_clk(link_clk), .link_cmd(link_cmd),
    .bank_select_inputs(bank_select_inputs), .row_address_inputs(row_address_inputs));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  // A zero mask means an error response is expected
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) begin
      apb_q.push_back(d);
      msk_q.push_back(m);
    end
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 20000) begin
      fail_count++;
      conclude();
    end
    if (psel && penable && pready === 1'b1 && !pwrite && apb_q.size() > 0) begin
      e = apb_q.pop_front();
      mk = msk_q.pop_front();
      check(pslverr, mk == 0);
      if (mk != 0) check(prdata & mk, e & mk);
    end
  end
  always @(posedge link_clk) begin
    lat <= (link_cmd == CMD_RD || link_cmd == CMD_RDA) ? 0 : lat + 1;
    if (rd_valid === 1'b1) begin
      if (pairs == 0) seen_lat = lat;
      if (pairs == 0) first_rise = rd_rise;
      if (pairs == 0) first_fall = rd_fall;
      pairs++;
    end else if (pairs != 0) begin
      e = burst_q.pop_front();
      check(pairs, e[7:0]);
      check(seen_lat, e >> 8);
      pairs = 0;
    end
  end
  task automatic read_case(input logic [1:0] bl, input logic chop, input logic ap,
                           input int cl, input int al, input logic fresh);
    if (fresh) begin
      b_v = $random(seed);
      r_v = $random(seed);
      c_v = $random(seed);
    end
    prev_rise = first_rise;
    apb(1'b1, OFS_MODE, 32'(bl) | 32'(cl) << MODE_CL_LSB | 32'(al) << MODE_AL_LSB, '1);
    burst_q.push_back(((bl == BL_FIX4 || (bl == BL_OTF && !chop)) ? 2 : 4) | (al + cl) << 8);
    m.issue(CMD_ACT, b_v, r_v);
    m.issue(ap ? CMD_RDA : CMD_RD, b_v, {r_v[14:13], chop, r_v[11:10], c_v});
    for (int i = 0; i < 300 && burst_q.size() > 0; i++) @(posedge link_clk);
    if (!fresh) check(first_rise, prev_rise);
    check(first_rise, DQ_W'(c_v));
    check(first_fall, DQ_W'(c_v + 1'b1));
    apb(1'b0, OFS_ROW, 32'(r_v), '1);
    if (!ap) apb(1'b0, OFS_STATUS, 32'(BK_ACT) << (2 * b_v), '1);
    if (!ap) m.issue(CMD_PRE, b_v, r_v);
  endtask : read_case
  task automatic status_after_pre(input logic [31:0] exp);
    repeat (TRP_CK + 4) @(posedge link_clk);
    apb(1'b0, OFS_STATUS, exp, '1);
  endtask : status_after_pre
  initial begin
    seed = 32'h931297d1;
    rstn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    apb(1'b0, OFS_MODE, MODE_RST, '1);
    apb(1'b0, OFS_STATUS, 32'h0, '1);
    apb(1'b0, OFS_CMD, 32'h0, '1);
    apb(1'b0, 8'h10, 32'h0, 32'h0);
    $display("reset and map test done");
    for (int j = 0; j < 3; j++)
      for (int k = 0; k < 4; k++) read_case(2'(j), k[0], k[1], 6, 0, k == 0);
    read_case(BL_OTF, 1'b1, 1'b0, 6, 5, 1'b1);
    read_case(BL_OTF, 1'b0, 1'b1, 9, 0, 1'b0);
    $display("burst and latency test done");
    m.issue(CMD_ACT, 3'h3, r_v);
    m.issue(CMD_ACT, 3'h5, r_v);
    m.issue(CMD_PRE, 3'h0, '0);
    m.issue(CMD_PRE, 3'h3, '0);
    m.issue(CMD_PRE, 3'h3, '0);
    status_after_pre(32'(BK_ACT) << 10);
    m.issue(CMD_PRA, 3'h5, '0);
    status_after_pre(32'h0);
    $display("precharge test done");
    check(rd_err, 1'b0);
    m.issue(CMD_RD, 3'h2, '0);
    repeat (40) @(posedge link_clk);
    check(rd_err, 1'b1);
    check(burst_q.size(), 0);
    $display("idle read test done");
    conclude();
  end
endmodule : ddrb_top_bench
